// ### dv/cawd_counter_array_assertions.sv
// Purpose: port checker for the counter array
// Assumes: sees only top ports; mode and pwm config mirrored from writes
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module cawd_counter_array_assertions
  import cawd_pkg::*;
#(
  parameter int NMOD = NUM_MODULES
)
(
  // clock and reset
  input wire logic            clk,
  input wire logic            rstn,
  // register access
  input wire logic [7:0]      sfrAddr,
  input wire logic [7:0]      sfrPage,
  input wire logic            sfrWrite,
  input wire logic            sfrRead,
  input wire logic [7:0]      sfrWdata,
  input wire logic [7:0]      sfrRdata,
  // outputs
  input wire logic [NMOD-1:0] moduleOutput,
  input wire logic            irqRequest,
  input wire logic            watchdogResetReq
);
  localparam logic [7:0] SVC_ADDR = ADDR_CMPH_0 + 8'h05;
  logic       modeAcc;
  logic       cfgAcc;
  logic [7:0] shadowMode;
  logic [7:0] shadowCfg;
  assign modeAcc = sfrAddr == ADDR_MODE && sfrPage == PAGE_BASE;
  assign cfgAcc  = sfrAddr == ADDR_MODE && sfrPage == PAGE_PWM;
  // mode mirror: only enable and lock move while the watchdog runs
  always_ff @(posedge clk)
    if (!rstn)
      shadowMode <= MODE_RESET;
    else if (sfrWrite && modeAcc && !shadowMode[MD_WDEN])
      shadowMode <= sfrWdata & MODE_WR_MASK;
    else if (sfrWrite && modeAcc)
      shadowMode <= {shadowMode[7], sfrWdata[MD_WDEN] | shadowMode[MD_LOCK],
                     shadowMode[MD_LOCK] | sfrWdata[MD_LOCK], shadowMode[4:0]};
  always_ff @(posedge clk)
    if (!rstn)
      shadowCfg <= PWM_RESET;
    else if (sfrWrite && cfgAcc)
      shadowCfg <= sfrWdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence cfgRead;
    sfrRead && cfgAcc && !sfrWrite;
  endsequence
  sequence cfgSoftSet;
    sfrWrite && cfgAcc && sfrWdata[PW_CYCLE_OVERFLOW_FLAG];
  endsequence
  a_reset_outputs_low: assert property ($rose(rstn) |-> moduleOutput == '0 &&
    sfrRdata == 8'h00 && !irqRequest && !watchdogResetReq) else $error("outputs not idle");
  a_mode_readback: assert property (sfrRead && modeAcc && !sfrWrite |=>
    sfrRdata == shadowMode) else $error("mode register read mismatch");
  a_cfg_readback: assert property (cfgRead |=>
    (sfrRdata & 8'hdf) == (shadowCfg & 8'hc3)) else $error("pwm config read mismatch");
  a_cfg_soft_set: assert property (cfgSoftSet ##[1:2] cfgRead |=> sfrRdata[PW_CYCLE_OVERFLOW_FLAG])
    else $error("cycle flag not set by software");
  a_cycle_irq_raised: assert property (cfgRead ##1 (sfrRdata[PW_CYCLE_OVERFLOW_IRQ_ENABLE] &&
    sfrRdata[PW_CYCLE_OVERFLOW_FLAG] && !sfrWrite) |-> irqRequest) else $error("cycle irq missing");
  a_wd_pulse_single: assert property (watchdogResetReq |=> !watchdogResetReq)
    else $error("watchdog pulse too long");
  a_service_no_reset: assert property (sfrWrite && sfrAddr == SVC_ADDR &&
    sfrPage == PAGE_BASE |=> !watchdogResetReq) else $error("reset on service write");
  a_low_write_idles: assert property (sfrWrite && sfrAddr == ADDR_CMPL_0 &&
    sfrPage == PAGE_BASE && !shadowCfg[PW_RELOAD_SELECT] |-> ##2 !moduleOutput[0])
    else $error("output high after low byte write");
endmodule : cawd_counter_array_assertions

bind cawd_counter_array cawd_counter_array_assertions #(.NMOD(NMOD)) uChk (.clk(clk),
  .rstn(rstn), .sfrAddr(sfrAddr), .sfrPage(sfrPage), .sfrWrite(sfrWrite),
  .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
  .moduleOutput(moduleOutput), .irqRequest(irqRequest), .watchdogResetReq(watchdogResetReq));

// ### dv/test_cawd_counter_array.sv
// Purpose: self-checking bench for the counter array
// Assumes: sysclk timebase for pwm, timer pulses driven by the bench
// Notes:   seed fixed, inputs move 2 ns after the rising edge
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin numErrors++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module test_cawd_counter_array
  import cawd_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  sfrAddr = 8'h00;
  logic [7:0]  sfrPage = 8'h00;
  logic        sfrWrite = 1'b0;
  logic        sfrRead = 1'b0;
  logic [7:0]  sfrWdata = 8'h00;
  logic [7:0]  sfrRdata;
  logic        cpuIdle = 1'b0;
  logic        timer0Ovf = 1'b0;
  logic        timer4Ovf = 1'b0;
  logic        timer5Ovf = 1'b0;
  logic [5:0]  moduleOutput;
  logic        irqRequest;
  logic        watchdogResetReq;
  int          numErrors = 0;
  int          compares = 0;
  logic [7:0]  k;
  logic [7:0]  a;
  logic [11:0] h;
  logic [15:0] c;
  logic        e;
  int          n;
  logic [1:0]  pins = 2'b00;
  logic [1:0]  prev;
  int          rises = 0;
  logic [2:0]  srcs [5] = '{SRC_T0, SRC_T4, SRC_T5, SRC_ECI, SRC_EXT8};

  cawd_counter_array #(.NMOD(6)) DUT (.clk(clk), .rstn(rstn), .sfrAddr(sfrAddr),
    .sfrPage(sfrPage), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .cpuIdle(cpuIdle), .timer0Ovf(timer0Ovf), .timer4Ovf(timer4Ovf),
    .timer5Ovf(timer5Ovf), .externalCountInput(pins[1]), .externalClock(pins[0]),
    .moduleOutput(moduleOutput), .irqRequest(irqRequest),
    .watchdogResetReq(watchdogResetReq));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  function automatic logic [11:0] expHigh(input int bits, input logic [15:0] cmp);
    return 12'((1 << bits) - cmp);
  endfunction : expHigh

  function automatic logic [7:0] expCfg(input logic [1:0] len, input logic cycle_overflow_irq_enable);
    return {1'b0, cycle_overflow_irq_enable, 1'b1, 3'h0, len};
  endfunction : expCfg

  task automatic wr(input logic [7:0] ad, input logic [7:0] pg, input logic [7:0] d);
    @(posedge clk);
    #2 sfrAddr = ad;
    sfrPage = pg;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(posedge clk);
    #2 sfrWrite = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] pg, output logic [7:0] d);
    @(posedge clk);
    #2 sfrAddr = ad;
    sfrPage = pg;
    sfrRead = 1'b1;
    @(posedge clk);
    #2 sfrRead = 1'b0;
    d = sfrRdata;
  endtask : rd

  task automatic rdChk(input logic [7:0] ad, input logic [7:0] pg, input logic [7:0] m,
                       input logic [7:0] exp);
    logic [7:0] d;
    rd(ad, pg, d);
    `CHK(d & m, exp)
  endtask : rdChk

  task automatic resetDut();
    @(posedge clk);
    #2 rstn = 1'b0;
    repeat (2) @(posedge clk);
    #2 rstn = 1'b1;
  endtask : resetDut

  task automatic countHigh(input int cyc, output logic [11:0] cnt);
    cnt = 12'h000;
    repeat (cyc)
    begin
      @(posedge clk);
      #2 cnt = cnt + 12'(moduleOutput[0]);
    end
  endtask : countHigh

  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finalReport

  initial
  begin
    #1500000 numErrors++;
    finalReport();
  end

  initial
  begin
    void'($urandom(88503));
    repeat (2) @(posedge clk);
    #2 rstn = 1'b1;
    // watchdog from reset, restricted writes, service and expiry
    rdChk(ADDR_MODE, PAGE_BASE, 8'hff, MODE_RESET);
    wr(ADDR_MODE, PAGE_BASE, 8'hce);
    rdChk(ADDR_MODE, PAGE_BASE, 8'hff, 8'h40);
    wr(ADDR_MMODE_0 + 8'h05, PAGE_BASE, 8'h00);
    rdChk(ADDR_MMODE_0 + 8'h05, PAGE_BASE, 8'hff, MMODE_TIMER);
    rdChk(ADDR_CTRL, PAGE_BASE, 8'h40, 8'h00);
    wr(ADDR_CMPL_0 + 8'h05, PAGE_BASE, 8'h01);
    wr(ADDR_CMPH_0 + 8'h05, PAGE_BASE, 8'haa);
    n = 0;
    while (watchdogResetReq !== 1'b1 && n < 3200)
    begin
      @(posedge clk);
      #2 n++;
    end
    `CHK(watchdogResetReq, 1'b1)
    `CHK(n > 3000, 1'b1)
    resetDut();
    wr(ADDR_MODE, PAGE_BASE, 8'h60);
    wr(ADDR_MODE, PAGE_BASE, 8'h00);
    rdChk(ADDR_MODE, PAGE_BASE, 8'hff, 8'h60);
    resetDut();
    wr(ADDR_MODE, PAGE_BASE, 8'h00);
    rdChk(ADDR_MODE, PAGE_BASE, 8'hff, 8'h00);
    $display("test watchdog done");
    // timer overflow, external count and external clock timebases with distracting pulses
    foreach (srcs[i])
    begin
      wr(ADDR_MODE, PAGE_BASE, {4'h0, srcs[i], 1'b0});
      wr(ADDR_CTRL, PAGE_BASE, 8'h00);
      wr(ADDR_CNT_LO, PAGE_BASE, 8'h00);
      wr(ADDR_CNT_HI, PAGE_BASE, 8'h00);
      wr(ADDR_CTRL, PAGE_BASE, 8'h40);
      k = 8'h00;
      for (int j = 0; j < 40; j++)
      begin
        @(posedge clk);
        #2 {timer0Ovf, timer4Ovf, timer5Ovf} = 3'($urandom);
        prev = pins;
        if (j % 2 == 0)
          pins = 2'($urandom);
        rises = rises + int'(!prev[0] && pins[0]);
        case (i)
          0: k = k + 8'(timer0Ovf);
          1: k = k + 8'(timer4Ovf);
          2: k = k + 8'(timer5Ovf);
          3: k = k + 8'(prev[1] && !pins[1]);
          default: k = k + 8'(!prev[0] && pins[0] && (rises % 8 == 0));
        endcase
      end
      @(posedge clk);
      #2 {timer0Ovf, timer4Ovf, timer5Ovf} = 3'h0;
      repeat (3) @(posedge clk);
      rdChk(ADDR_CNT_LO, PAGE_BASE, 8'hff, k);
    end
    // idle suspend on the sysclk timebase
    wr(ADDR_MODE, PAGE_BASE, 8'h88);
    cpuIdle = 1'b1;
    rd(ADDR_CNT_LO, PAGE_BASE, a);
    repeat (10) @(posedge clk);
    rdChk(ADDR_CNT_LO, PAGE_BASE, 8'hff, a);
    cpuIdle = 1'b0;
    // counter overflow flag and its interrupt enable
    wr(ADDR_CTRL, PAGE_BASE, 8'h00);
    wr(ADDR_CNT_LO, PAGE_BASE, 8'hff);
    wr(ADDR_CNT_HI, PAGE_BASE, 8'hff);
    wr(ADDR_MODE, PAGE_BASE, 8'h09);
    `CHK(irqRequest, 1'b0)
    wr(ADDR_CTRL, PAGE_BASE, 8'h40);
    repeat (2) @(posedge clk);
    #2 `CHK(irqRequest, 1'b1)
    rdChk(ADDR_CTRL, PAGE_BASE, 8'h80, 8'h80);
    wr(ADDR_MODE, PAGE_BASE, 8'h08);
    `CHK(irqRequest, 1'b0)
    $display("test timebase done");
    // n-bit pwm for the 9, 10 and 11 bit cycle lengths, reload equal to compare
    for (int len = 1; len < 4; len++)
    begin
      n = 8 + len;
      c = (len == 3) ? 16'((1 << n) - 1) : 16'(1 + $urandom % ((1 << n) - 1));
      e = 1'($urandom);
      wr(ADDR_CTRL, PAGE_BASE, 8'h00);
      wr(ADDR_CNT_LO, PAGE_BASE, 8'h00);
      wr(ADDR_CNT_HI, PAGE_BASE, 8'h00);
      for (int r = 1; r >= 0; r--)
      begin
        wr(ADDR_MODE, PAGE_PWM, {1'(r), e, 4'h0, 2'(len)});
        wr(ADDR_CMPL_0, PAGE_BASE, c[7:0]);
        wr(ADDR_CMPH_0, PAGE_BASE, c[15:8]);
      end
      wr(ADDR_MMODE_0, PAGE_BASE, 8'h4a);
      wr(ADDR_CTRL, PAGE_BASE, 8'h40);
      a = 8'h00;
      for (int s = 1; s >= 0; s--)
        while (moduleOutput[0] !== 1'(s) && a < 8'hff)
        begin
          repeat (20) @(posedge clk);
          #2 a++;
        end
      countHigh(1 << n, h);
      `CHK(h, expHigh(n, c))
      `CHK(moduleOutput[5:1], 5'h00)
      rdChk(ADDR_MODE, PAGE_PWM, 8'hff, expCfg(2'(len), e));
      `CHK(irqRequest, e)
      rdChk(ADDR_CTRL, PAGE_BASE, 8'h01, 8'h01);
      wr(ADDR_CMPL_0, PAGE_BASE, 8'h00);
      countHigh((1 << n) + 4, h);
      `CHK(h, 12'h000)
      wr(ADDR_MODE, PAGE_PWM, {6'h00, 2'(len)});
      $display("test pwm length %0d done", n);
    end
    // software set of the cycle flag and its interrupt gate
    wr(ADDR_MODE, PAGE_PWM, 8'h20);
    `CHK(irqRequest, 1'b0)
    wr(ADDR_MODE, PAGE_PWM, 8'h60);
    `CHK(irqRequest, 1'b1)
    rdChk(ADDR_MODE, PAGE_PWM, 8'he3, 8'h60);
    $display("test cycle flag done");
    finalReport();
  end
endmodule : test_cawd_counter_array

// ### hdl/cawd_channel.sv
// Purpose: one compare module: compare, reload and mode bytes, n-bit pwm output
// Assumes: tick and next counter value come from the counter array on the same clock
// Notes:   compare and reload bytes share addresses, chosen by the caller
`timescale 1ns/1ps
module cawd_channel
  import cawd_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // counter array
  input  wire logic             tick,
  input  wire logic [LOW_W-1:0] cntLow,
  input  wire logic             cycOvf,
  input  wire logic [1:0]       lenSel,
  input  wire logic             forceTimer,
  // register writes
  input  wire logic             wrLow,
  input  wire logic             wrHigh,
  input  wire logic             wrMode,
  input  wire logic             toReload,
  input  wire logic [7:0]       wrData,
  input  wire logic             clrMatch,
  // state
  output logic      [15:0]      cmpValue,
  output logic      [15:0]      reloadValue,
  output logic      [7:0]       modeBits,
  output logic                  matchFlag,
  output logic                  modOut
);
  typedef struct packed {
    logic [15:0] cmp;
    logic [15:0] rld;
    logic [7:0]  mode;
    logic        flag;
    logic        out;
  } cawd_ch_t;

  cawd_ch_t st;
  cawd_ch_t next_st;
  logic     pwmOn;
  logic     match;

  always_comb
  begin
    next_st = st;
    pwmOn   = next_st.mode[MM_CMPEN] && next_st.mode[MM_PWMEN] && (lenSel != LEN_8);
    match   = tick && (((cntLow ^ st.cmp[LOW_W-1:0]) & cawd_len_mask(lenSel)) == '0);
    if (wrMode)
    begin
      next_st.mode = wrData;
    end
    if (wrLow && toReload)
    begin
      next_st.rld[7:0] = wrData;
    end
    else if (wrLow)
    begin
      next_st.cmp[7:0]          = wrData;
      next_st.mode[MM_CMPEN]    = 1'b0;
    end
    if (wrHigh && toReload)
    begin
      next_st.rld[15:8] = wrData;
    end
    else if (wrHigh)
    begin
      next_st.cmp[15:8]         = wrData;
      next_st.mode[MM_CMPEN]    = 1'b1;
    end
    if (forceTimer)
    begin
      next_st.mode = MMODE_TIMER;
    end
    pwmOn = next_st.mode[MM_CMPEN] && next_st.mode[MM_PWMEN] && (lenSel != LEN_8) && !forceTimer;
    if (clrMatch)
    begin
      next_st.flag = 1'b0;
    end
    if (match && st.mode[MM_MATEN] && pwmOn)
    begin
      next_st.flag = 1'b1;
    end
    if (!next_st.mode[MM_CMPEN] || !pwmOn)
    begin
      next_st.out = 1'b0;
    end
    else if (cycOvf)
    begin
      next_st.out = 1'b0;
      next_st.cmp = st.rld;
    end
    else if (match)
    begin
      next_st.out = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st <= '{cmp: '0, rld: '0, mode: MMODE_RESET, flag: 1'b0, out: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign cmpValue    = st.cmp;
  assign reloadValue = st.rld;
  assign modeBits    = st.mode;
  assign matchFlag   = st.flag;
  assign modOut      = st.out;
endmodule : cawd_channel

// ### hdl/cawd_counter_array.sv
// Purpose: counter array with timebase select, n-bit pwm modules and watchdog
// Assumes: special function register strobes on clk; read data one cycle after read
// Notes:   watchdog reset request is a one-cycle pulse for the system reset logic unless ticks come on consecutive cycles
`timescale 1ns/1ps
module cawd_counter_array
  import cawd_pkg::*;
#(
  parameter int NMOD = NUM_MODULES
)
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rstn,
  // special function register access
  input  wire logic [7:0]      sfrAddr,
  input  wire logic [7:0]      sfrPage,
  input  wire logic            sfrWrite,
  input  wire logic            sfrRead,
  input  wire logic [7:0]      sfrWdata,
  output logic      [7:0]      sfrRdata,
  // system
  input  wire logic            cpuIdle,
  input  wire logic            timer0Ovf,
  input  wire logic            timer4Ovf,
  input  wire logic            timer5Ovf,
  // pins
  input  wire logic            externalCountInput,
  input  wire logic            externalClock,
  output logic      [NMOD-1:0] moduleOutput,
  // requests
  output logic                 irqRequest,
  output logic                 watchdogResetReq
);
  typedef struct packed {
    logic [7:0]       mode;
    logic [7:0]       pwm;
    logic [7:0]       ctrl;
    logic [CNT_W-1:0] cnt;
    logic [3:0]       pre;
    logic [2:0]       extDiv;
    logic             eci1;
    logic             eci2;
    logic             eci3;
    logic             ext1;
    logic             ext2;
    logic             ext3;
    logic [7:0]       rdata;
    logic             wdRst;
  } cawd_st_t;

  cawd_st_t         st;
  cawd_st_t         next_st;
  logic             wdOn;
  logic             running;
  logic             srcTick;
  logic             tick;
  logic [CNT_W-1:0] cntNext;
  logic             cycOvf;
  logic             wrMode;
  logic             wrPwm;
  logic             wrCtrl;
  logic [NMOD-1:0]  wrLow;
  logic [NMOD-1:0]  wrHigh;
  logic [NMOD-1:0]  wrMmode;
  logic [NMOD-1:0]  clrMatch;
  logic [NMOD-1:0]  matchFlag;
  logic [7:0]       chWdata [NMOD];
  logic [15:0]      cmpValue [NMOD];
  logic [15:0]      rldValue [NMOD];
  logic [7:0]       modeBits [NMOD];
  logic [7:0]       wdService;

  // whether an address is module i's entry within a block of module registers
  function automatic logic in_block(input logic [7:0] a, input logic [7:0] base, input int i);
    return (a == (base + 8'(i)));
  endfunction : in_block

  assign wdOn      = st.mode[MD_WDEN];
  assign wrMode    = sfrWrite && (sfrAddr == ADDR_MODE) && (sfrPage == PAGE_BASE);
  assign wrPwm     = sfrWrite && (sfrAddr == ADDR_MODE) && (sfrPage == PAGE_PWM);
  assign wrCtrl    = sfrWrite && (sfrAddr == ADDR_CTRL) && (sfrPage == PAGE_BASE);
  assign wdService = st.cnt[15:8] + cmpValue[WD_MODULE][7:0];

  // module register strobes
  generate
    for (genvar i = 0; i < NMOD; i++)
    begin : g_mod
      logic wdMod;
      assign wdMod       = (i == WD_MODULE) && wdOn;
      assign wrLow[i]    = sfrWrite && (sfrPage == PAGE_BASE) && in_block(sfrAddr, ADDR_CMPL_0, i);
      assign wrHigh[i]   = sfrWrite && (sfrPage == PAGE_BASE) && in_block(sfrAddr, ADDR_CMPH_0, i);
      assign wrMmode[i]  = sfrWrite && (sfrPage == PAGE_BASE)
                           && in_block(sfrAddr, ADDR_MMODE_0, i) && !wdMod;
      assign clrMatch[i] = wrCtrl && !sfrWdata[i];
      assign chWdata[i]  = (wdMod && wrHigh[i]) ? wdService : sfrWdata;

      cawd_channel u_channel (
        .clk         (clk),
        .rstn        (rstn),
        .tick        (tick),
        .cntLow      (cntNext[LOW_W-1:0]),
        .cycOvf      (cycOvf),
        .lenSel      (st.pwm[PW_LEN_HI:PW_LEN_LO]),
        .forceTimer  (wdMod),
        .wrLow       (wrLow[i]),
        .wrHigh      (wrHigh[i]),
        .wrMode      (wrMmode[i]),
        .toReload    (st.pwm[PW_RELOAD_SELECT] && !wdMod),
        .wrData      (chWdata[i]),
        .clrMatch    (clrMatch[i]),
        .cmpValue    (cmpValue[i]),
        .reloadValue (rldValue[i]),
        .modeBits    (modeBits[i]),
        .matchFlag   (matchFlag[i]),
        .modOut      (moduleOutput[i])
      );
    end
  endgenerate

  // timebase and counter step
  always_comb
  begin
    case (st.mode[MD_SRC_HI:MD_SRC_LO])
      SRC_DIV12: srcTick = (st.pre == PRE_LAST);
      SRC_DIV4:  srcTick = (st.pre[1:0] == PRE_DIV4_TAP);
      SRC_T0:    srcTick = timer0Ovf;
      SRC_ECI:   srcTick = st.eci3 && !st.eci2;
      SRC_SYS:   srcTick = 1'b1;
      SRC_EXT8:  srcTick = st.ext2 && !st.ext3 && (st.extDiv == EXT_LAST);
      SRC_T4:    srcTick = timer4Ovf;
      default:   srcTick = timer5Ovf;
    endcase
    running = (st.ctrl[CT_RUN] || wdOn) && !(cpuIdle && st.mode[MD_IDLE]);
    tick    = running && srcTick;
    cntNext = st.cnt + 16'h0001;
    cycOvf  = tick && ((st.cnt[LOW_W-1:0] & cawd_len_mask(st.pwm[PW_LEN_HI:PW_LEN_LO]))
              == cawd_len_mask(st.pwm[PW_LEN_HI:PW_LEN_LO]));
  end

  // register state
  always_comb
  begin
    next_st      = st;
    next_st.eci1 = externalCountInput;
    next_st.eci2 = st.eci1;
    next_st.eci3 = st.eci2;
    next_st.ext1 = externalClock;
    next_st.ext2 = st.ext1;
    next_st.ext3 = st.ext2;
    next_st.pre  = (st.pre == PRE_LAST) ? 4'h0 : st.pre + 4'h1;
    if (st.ext2 && !st.ext3)
    begin
      next_st.extDiv = st.extDiv + 3'h1;
    end
    // mode register
    if (wrMode && wdOn)
    begin
      next_st.mode[MD_WDEN] = sfrWdata[MD_WDEN] || st.mode[MD_LOCK];
      next_st.mode[MD_LOCK] = st.mode[MD_LOCK] || sfrWdata[MD_LOCK];
    end
    else if (wrMode)
    begin
      next_st.mode = sfrWdata & MODE_WR_MASK;
    end
    // pwm configuration
    if (wrPwm)
    begin
      next_st.pwm = sfrWdata & PWM_WR_MASK;
    end
    if (cycOvf)
    begin
      next_st.pwm[PW_CYCLE_OVERFLOW_FLAG] = 1'b1;
    end
    // control: run bit, overflow flag
    if (wrCtrl)
    begin
      next_st.ctrl[CT_RUN] = sfrWdata[CT_RUN];
      next_st.ctrl[CT_CF]  = sfrWdata[CT_CF];
    end
    // counter
    if (tick)
    begin
      next_st.cnt = cntNext;
      if (st.cnt == '1)
      begin
        next_st.ctrl[CT_CF] = 1'b1;
      end
    end
    if (!wdOn && sfrWrite && (sfrPage == PAGE_BASE))
    begin
      if (sfrAddr == ADDR_CNT_LO)
      begin
        next_st.cnt[7:0] = sfrWdata;
      end
      else if (sfrAddr == ADDR_CNT_HI)
      begin
        next_st.cnt[15:8] = sfrWdata;
      end
    end
    // watchdog
    next_st.wdRst = wdOn && tick && (cntNext[15:8] == cmpValue[WD_MODULE][15:8])
                    && !wrHigh[WD_MODULE];
    // read data
    next_st.rdata = st.rdata;
    if (sfrRead)
    begin
      next_st.rdata = 8'h00;
      if (sfrAddr == ADDR_MODE && sfrPage == PAGE_BASE)
      begin
        next_st.rdata = st.mode;
      end
      else if (sfrAddr == ADDR_MODE && sfrPage == PAGE_PWM)
      begin
        next_st.rdata = st.pwm;
      end
      else if (sfrPage == PAGE_BASE && sfrAddr == ADDR_CTRL)
      begin
        next_st.rdata = {st.ctrl[CT_CF], st.ctrl[CT_RUN], 6'(matchFlag)};
      end
      else if (sfrPage == PAGE_BASE && sfrAddr == ADDR_CNT_LO)
      begin
        next_st.rdata = st.cnt[7:0];
      end
      else if (sfrPage == PAGE_BASE && sfrAddr == ADDR_CNT_HI)
      begin
        next_st.rdata = st.cnt[15:8];
      end
      else if (sfrPage == PAGE_BASE)
      begin
        for (int i = 0; i < NMOD; i++)
        begin
          if (in_block(sfrAddr, ADDR_MMODE_0, i))
          begin
            next_st.rdata = modeBits[i];
          end
          else if (in_block(sfrAddr, ADDR_CMPL_0, i))
          begin
            next_st.rdata = st.pwm[PW_RELOAD_SELECT] ? rldValue[i][7:0] : cmpValue[i][7:0];
          end
          else if (in_block(sfrAddr, ADDR_CMPH_0, i))
          begin
            next_st.rdata = st.pwm[PW_RELOAD_SELECT] ? rldValue[i][15:8] : cmpValue[i][15:8];
          end
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st      <= '0;
      st.mode <= MODE_RESET;
      st.pwm  <= PWM_RESET;
      st.ctrl <= CTRL_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sfrRdata         = st.rdata;
  assign watchdogResetReq = st.wdRst;
  assign irqRequest       = (st.ctrl[CT_CF] && st.mode[MD_ECF])
                            || (st.pwm[PW_CYCLE_OVERFLOW_FLAG] && st.pwm[PW_CYCLE_OVERFLOW_IRQ_ENABLE]);
endmodule : cawd_counter_array

// ### shared/cawd_pkg.sv
// Purpose: constants shared by the counter array, pwm and watchdog logic
// Assumes: byte-wide special function register access with an address and a page
// Notes:   register offsets, field positions, reset values and timebase codes
package cawd_pkg;
  localparam int        NUM_MODULES  = 6;
  localparam int        WD_MODULE    = 5;
  localparam int        CNT_W        = 16;
  localparam int        LOW_W        = 11;
  // register locations
  localparam logic [7:0] ADDR_MODE      = 8'hd9;
  localparam logic [7:0] PAGE_BASE      = 8'h00;
  localparam logic [7:0] PAGE_PWM       = 8'h0f;
  localparam logic [7:0] ADDR_CTRL      = 8'hd8;
  localparam logic [7:0] ADDR_CNT_LO    = 8'hf9;
  localparam logic [7:0] ADDR_CNT_HI    = 8'hfa;
  localparam logic [7:0] ADDR_MMODE_0   = 8'hda;
  localparam logic [7:0] ADDR_CMPL_0    = 8'he0;
  localparam logic [7:0] ADDR_CMPH_0    = 8'he8;
  // mode register fields
  localparam int        MD_IDLE      = 7;
  localparam int        MD_WDEN      = 6;
  localparam int        MD_LOCK      = 5;
  localparam int        MD_SRC_HI    = 3;
  localparam int        MD_SRC_LO    = 1;
  localparam int        MD_ECF       = 0;
  localparam logic [7:0] MODE_RESET     = 8'h40;
  localparam logic [7:0] MODE_WR_MASK   = 8'hef;
  // pwm configuration fields
  localparam int        PW_RELOAD_SELECT     = 7;
  localparam int        PW_CYCLE_OVERFLOW_IRQ_ENABLE      = 6;
  localparam int        PW_CYCLE_OVERFLOW_FLAG      = 5;
  localparam int        PW_LEN_HI    = 1;
  localparam int        PW_LEN_LO    = 0;
  localparam logic [7:0] PWM_RESET      = 8'h00;
  localparam logic [7:0] PWM_WR_MASK    = 8'he3;
  // control register fields
  localparam int        CT_CF        = 7;
  localparam int        CT_RUN       = 6;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  // module mode fields
  localparam int        MM_CMPEN     = 6;
  localparam int        MM_MATEN     = 3;
  localparam int        MM_PWMEN     = 1;
  localparam logic [7:0] MMODE_RESET    = 8'h00;
  localparam logic [7:0] MMODE_TIMER    = 8'h48;
  // cycle lengths
  localparam logic [1:0] LEN_8          = 2'h0;
  localparam logic [1:0] LEN_9          = 2'h1;
  localparam logic [1:0] LEN_10         = 2'h2;
  localparam logic [1:0] LEN_11         = 2'h3;
  // timebase codes
  localparam logic [2:0] SRC_DIV12      = 3'h0;
  localparam logic [2:0] SRC_DIV4       = 3'h1;
  localparam logic [2:0] SRC_T0         = 3'h2;
  localparam logic [2:0] SRC_ECI        = 3'h3;
  localparam logic [2:0] SRC_SYS        = 3'h4;
  localparam logic [2:0] SRC_EXT8       = 3'h5;
  localparam logic [2:0] SRC_T4         = 3'h6;
  localparam logic [2:0] SRC_T5         = 3'h7;
  localparam logic [3:0] PRE_LAST       = 4'hb;
  localparam logic [1:0] PRE_DIV4_TAP   = 2'h3;
  localparam logic [2:0] EXT_LAST       = 3'h7;

  // low counter bits that form one pwm cycle
  function automatic logic [LOW_W-1:0] cawd_len_mask(input logic [1:0] lenSel);
    logic [LOW_W-1:0] m;
    m = 11'h0ff;
    case (lenSel)
      LEN_9:   m = 11'h1ff;
      LEN_10:  m = 11'h3ff;
      LEN_11:  m = 11'h7ff;
      default: m = 11'h0ff;
    endcase
    return m;
  endfunction : cawd_len_mask
endpackage : cawd_pkg
